// >>> pkg/glp_regs.svh
// register offsets, field positions, reset values and timing for glp
`ifndef GLP_REGS_SVH
`define GLP_REGS_SVH
`define GLP_CFG_OFFSET     8'h88
`define GLP_LED_LSB        28
`define GLP_POL_LSB        24
`define GLP_EE_LSB         20
`define GLP_BUF_LSB        16
`define GLP_DIR_LSB        8
`define GLP_XOUT_LSB       3
`define GLP_DATA_LSB       0
`define GLP_CFG_RESET      32'h0000_0000
`define GLP_CFG_WMASK      32'h7777_071F
`define GLP_IRQ_MIN_NS     40
`define GLP_CLK_NS         25
`endif

// >>> pkg/glp_pkg.sv
// types shared by the glp pin configuration block
package glp_pkg;
  // roles of the eeprom data and clock pins
  typedef enum logic [2:0] {
    GLP_EE_EEPROM  = 3'h0,
    GLP_EE_XOUT    = 3'h1,
    GLP_EE_RSV2    = 3'h2,
    GLP_EE_X3_RXDV = 3'h3,
    GLP_EE_RSV4    = 3'h4,
    GLP_EE_TXEN_X4 = 3'h5,
    GLP_EE_TXEN_RX = 3'h6,
    GLP_EE_CLKS    = 3'h7
  } glp_ee_sel_t;
endpackage : glp_pkg

// >>> src/glp_sync.sv
// two-stage synchroniser for a bus of pin levels
`timescale 1ns/1ps
module glp_sync #(
  parameter int W = 3
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  // levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;  // first stage, read only by second

  // first stage feeds second stage and nothing else
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : glp_sync

// >>> src/glp_top.sv
// gpio and led pin configuration register with pin muxing
`timescale 1ns/1ps
`include "glp_regs.svh"
module glp_top #(
  parameter int NPIN = 3
) (
  // clock and reset
  input  wire logic            ref_clk,
  input  wire logic            rst_b,
  // register port
  input  wire logic [7:0]      reg_addr,
  input  wire logic [31:0]     reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic      [31:0]     reg_rdata,
  // general pins, three signals each
  input  wire logic [NPIN-1:0] general_pin_i,
  output logic      [NPIN-1:0] general_pin_o,
  output logic      [NPIN-1:0] general_pin_oe,
  // led status sources from the mac and phy
  input  wire logic [NPIN-1:0] led_status,
  // interrupt status side
  input  wire logic [NPIN-1:0] pin_irq_enable,
  output logic      [NPIN-1:0] pin_irq_level,
  output logic                 pin_irq,
  // eeprom controller side
  input  wire logic            ee_data_out,
  input  wire logic            ee_data_oe,
  input  wire logic            ee_clock_out,
  output logic                 ee_data_in,
  // mii debug signals
  input  wire logic            mii_tx_en,
  input  wire logic            mii_rx_dv,
  input  wire logic            mii_tx_clk,
  input  wire logic            mii_rx_clk,
  // eeprom data pin
  input  wire logic            eeprom_data_pin_i,
  output logic                 eeprom_data_pin_o,
  output logic                 eeprom_data_pin_oe,
  // eeprom clock pin
  output logic                 eeprom_clock_pin_o,
  output logic                 eeprom_clock_pin_oe
);
  // inputs must stay active for this many cycles to be trusted
  localparam int IRQ_MIN_CYC =
    (`GLP_IRQ_MIN_NS + `GLP_CLK_NS - 1) / `GLP_CLK_NS;

  logic [NPIN-1:0] led_select_q;        // led role per pin
  logic [NPIN-1:0] pin_irq_polarity_q;  // active level per pin
  logic [2:0]      eeprom_pin_select_q; // eeprom pin role code
  logic [NPIN-1:0] pin_driver_type_q;   // 1 push-pull, 0 open-drain
  logic [NPIN-1:0] pin_direction_q;     // 1 output
  logic [1:0]      extra_output_value_q;// values for outputs 3 and 4
  logic [NPIN-1:0] pin_data_value_q;    // written output data
  logic [NPIN-1:0] pin_sync;            // synchronised pin levels
  logic [31:0]     rd_d;                // read data next
  logic            cfg_hit;             // address decode
  glp_pkg::glp_ee_sel_t ee_sel;         // decoded eeprom role

  // true when this write targets the configuration register
  function automatic logic wr_hit(input logic [7:0] a, input logic w);
    return w && (a == `GLP_CFG_OFFSET);
  endfunction : wr_hit

  assign cfg_hit = (reg_addr == `GLP_CFG_OFFSET);
  assign ee_sel  = glp_pkg::glp_ee_sel_t'(eeprom_pin_select_q);

  // pin levels brought onto ref_clk before any use
  glp_sync #(.W(NPIN)) u_sync (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .async_in (general_pin_i),
    .sync_out (pin_sync)
  );

  // configuration fields, only defined bits stored
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      led_select_q         <= '0;
      pin_irq_polarity_q   <= '0;
      eeprom_pin_select_q  <= 3'h0;
      pin_driver_type_q    <= '0;
      pin_direction_q      <= '0;
      extra_output_value_q <= 2'h0;
      pin_data_value_q     <= '0;
    end else if (wr_hit(reg_addr, reg_wr)) begin
      led_select_q         <= reg_wdata[`GLP_LED_LSB +: NPIN];
      pin_irq_polarity_q   <= reg_wdata[`GLP_POL_LSB +: NPIN];
      // no guard against mid-cycle change; software owns that
      eeprom_pin_select_q  <= reg_wdata[`GLP_EE_LSB +: 3];
      pin_driver_type_q    <= reg_wdata[`GLP_BUF_LSB +: NPIN];
      pin_direction_q      <= reg_wdata[`GLP_DIR_LSB +: NPIN];
      extra_output_value_q <= reg_wdata[`GLP_XOUT_LSB +: 2];
      pin_data_value_q     <= reg_wdata[`GLP_DATA_LSB +: NPIN];
    end
  end

  // read image; data bits show live synchronised levels
  always_comb begin
    rd_d = 32'h0000_0000;
    if (cfg_hit) begin
      rd_d[`GLP_LED_LSB +: NPIN]  = led_select_q;
      rd_d[`GLP_POL_LSB +: NPIN]  = pin_irq_polarity_q;
      rd_d[`GLP_EE_LSB +: 3]      = eeprom_pin_select_q;
      rd_d[`GLP_BUF_LSB +: NPIN]  = pin_driver_type_q;
      rd_d[`GLP_DIR_LSB +: NPIN]  = pin_direction_q;
      rd_d[`GLP_XOUT_LSB +: 2]    = extra_output_value_q;
      rd_d[`GLP_DATA_LSB +: NPIN] = pin_sync;
    end
  end

  // read data stands one cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= rd_d;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // general pin drivers: led, push-pull or open-drain
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (led_select_q[i]) begin
        // leds sink current, so drive low when status is on
        general_pin_o[i]  = ~led_status[i];
        general_pin_oe[i] = 1'b1;
      end else if (pin_direction_q[i]) begin
        if (pin_driver_type_q[i]) begin
          general_pin_o[i]  = pin_data_value_q[i];
          general_pin_oe[i] = 1'b1;
        end else begin
          // open-drain: pull low only, release for high
          general_pin_o[i]  = 1'b0;
          general_pin_oe[i] = ~pin_data_value_q[i];
        end
      end else begin
        general_pin_o[i]  = 1'b0;
        general_pin_oe[i] = 1'b0;
      end
    end
  end

  // qualified level per pin; short glitches under two cycles dropped
  logic [NPIN-1:0] lvl_hist_q;          // active level last cycle
  logic [NPIN-1:0] lvl_now;             // active level this cycle
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      // polarity picks which level counts as active
      lvl_now[i] = ~(pin_sync[i] ^ pin_irq_polarity_q[i]);
    end
  end

  // history register lets a level count only once held 40 ns
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      lvl_hist_q <= '0;
    end else begin
      lvl_hist_q <= lvl_now;
    end
  end

  // status level to the interrupt status register, and gated line
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pin_irq_level <= '0;
      pin_irq       <= 1'b0;
    end else begin
      // IRQ_MIN_CYC is 2: current plus previous cycle
      pin_irq_level <= (IRQ_MIN_CYC > 1) ?
                       (lvl_now & lvl_hist_q) : lvl_now;
      pin_irq       <= |(lvl_now & lvl_hist_q & pin_irq_enable);
    end
  end

  // eeprom and debug pin roles
  always_comb begin
    ee_data_in          = eeprom_data_pin_i;
    eeprom_data_pin_o   = 1'b0;
    eeprom_data_pin_oe  = 1'b1;
    eeprom_clock_pin_o  = 1'b0;
    eeprom_clock_pin_oe = 1'b1;
    case (ee_sel)
      glp_pkg::GLP_EE_EEPROM: begin
        eeprom_data_pin_o  = ee_data_out;
        eeprom_data_pin_oe = ee_data_oe;
        eeprom_clock_pin_o = ee_clock_out;
      end
      glp_pkg::GLP_EE_XOUT: begin
        eeprom_data_pin_o  = extra_output_value_q[0];
        eeprom_clock_pin_o = extra_output_value_q[1];
      end
      glp_pkg::GLP_EE_X3_RXDV: begin
        eeprom_data_pin_o  = extra_output_value_q[0];
        eeprom_clock_pin_o = mii_rx_dv;
      end
      glp_pkg::GLP_EE_TXEN_X4: begin
        eeprom_data_pin_o  = mii_tx_en;
        eeprom_clock_pin_o = extra_output_value_q[1];
      end
      glp_pkg::GLP_EE_TXEN_RX: begin
        eeprom_data_pin_o  = mii_tx_en;
        eeprom_clock_pin_o = mii_rx_dv;
      end
      glp_pkg::GLP_EE_CLKS: begin
        eeprom_data_pin_o  = mii_tx_clk;
        eeprom_clock_pin_o = mii_rx_clk;
      end
      default: begin
        // reserved codes: pins released, safest undefined behaviour
        eeprom_data_pin_oe  = 1'b0;
        eeprom_clock_pin_oe = 1'b0;
      end
    endcase
  end
endmodule : glp_top

// >>> verif/glp_top_assertions.sv
// assertion checker bound to the glp pin configuration block
`timescale 1ns/1ps
module glp_chk #(
  parameter int NPIN = 3
) (
  // clock, reset and register port
  input wire logic            ref_clk,
  input wire logic            rst_b,
  input wire logic [7:0]      reg_addr,
  input wire logic [31:0]     reg_wdata,
  input wire logic            reg_wr,
  input wire logic            reg_rd,
  input wire logic [31:0]     reg_rdata,
  // general pins and interrupt side
  input wire logic [NPIN-1:0] general_pin_i,
  input wire logic [NPIN-1:0] general_pin_o,
  input wire logic [NPIN-1:0] general_pin_oe,
  input wire logic [NPIN-1:0] led_status,
  input wire logic [NPIN-1:0] pin_irq_enable,
  input wire logic [NPIN-1:0] pin_irq_level,
  input wire logic            pin_irq
);
  logic [31:0] cfg_q;  // shadow of the configuration word
  // shadow copy kept from bus traffic alone, never from the design
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cfg_q <= 32'h0000_0000;
    end else if (reg_wr && reg_addr == 8'h88) begin
      cfg_q <= reg_wdata & 32'h7777_071F;
    end
  end
  wire [2:0] led = cfg_q[30:28];                 // pins owned by leds
  wire [2:0] drv = ~led & cfg_q[10:8];           // general outputs
  wire [2:0] pp  = drv & cfg_q[18:16];           // push-pull pins
  wire [2:0] od  = drv & ~cfg_q[18:16];          // open-drain pins
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // six samples cover both sync flops and the two-cycle qualifier
  sequence s_act0; (general_pin_i[0] == cfg_q[24]) [*6]; endsequence
  sequence s_read; reg_rd && reg_addr == 8'h88; endsequence
  a_led_drive: assert property ((general_pin_oe & led) == led
    && ((general_pin_o ^ ~led_status) & led) == 3'h0) else $error("led pin");
  a_push_pull: assert property (((~general_pin_oe
    | (general_pin_o ^ cfg_q[2:0])) & pp) == 3'h0) else $error("push-pull");
  a_open_drain: assert property (((general_pin_o
    | (general_pin_oe ^ ~cfg_q[2:0])) & od) == 3'h0) else $error("open-drain");
  a_input_float: assert property ((general_pin_oe & ~led & ~cfg_q[10:8])
    == 3'h0) else $error("input driven");
  a_read_fields: assert property (s_read |=> ((reg_rdata ^ $past(cfg_q))
    & 32'hFFFF_FFF8) == 32'h0) else $error("read fields");
  a_read_idle: assert property (!(reg_rd && reg_addr == 8'h88)
    |=> reg_rdata == 32'h0) else $error("read idle");
  a_irq_gate: assert property ((pin_irq_enable == 3'h0) [*2]
    |-> !pin_irq) else $error("irq not gated");
  a_pol_level: assert property (s_act0 |-> pin_irq_level[0])
    else $error("level missed");
endmodule : glp_chk
bind glp_top glp_chk #(.NPIN(NPIN)) u_glp_chk (.*);

// >>> verif/glp_pin_model.sv
// outside world of the pins: pull-ups plus an optional external driver
`timescale 1ns/1ps
module glp_pin_model (
  // design drive
  input  wire logic [2:0] pin_o,
  input  wire logic [2:0] pin_oe,
  input  wire logic       ee_o,
  input  wire logic       ee_oe,
  // outside drive
  input  wire logic [2:0] ext_val,
  input  wire logic [2:0] ext_oe,
  // resolved wire levels
  output logic      [2:0] pin_lvl,
  output logic            ee_lvl
);
  // released lines take the outside drive where enabled, else the pull-up level, never a stale value
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pin_lvl[i] = pin_oe[i] ? pin_o[i] : (ext_oe[i] ? ext_val[i] : 1'h1);
    end
    ee_lvl = ee_oe ? ee_o : 1'h1;  // idle memory leaves data released
  end
endmodule : glp_pin_model

// >>> verif/tb_gpio_led_pin_config.sv
// self-checking bench for the gpio and led pin configuration block
`timescale 1ns/1ps
module tb_gpio_led_pin_config;
  logic        ref_clk, rst_b, reg_wr, reg_rd, ee_data_oe, pin_irq;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [2:0]  pin_o, pin_oe, pin_lvl, led_status, irq_en, irq_lvl;
  logic [2:0]  ext_val, ext_oe;
  logic [5:0]  src;  // tx_en rx_dv tx_clk rx_clk, controller data, clock
  logic        ee_in, ee_lvl, ed_o, ed_oe, ec_o, ec_oe;
  int          error_cnt, n_compared;
  glp_top u_glp_top (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .general_pin_i(pin_lvl), .general_pin_o(pin_o),
    .general_pin_oe(pin_oe), .led_status(led_status), .pin_irq(pin_irq),
    .pin_irq_enable(irq_en), .pin_irq_level(irq_lvl), .ee_data_in(ee_in),
    .ee_data_out(src[1]), .ee_data_oe(ee_data_oe), .ee_clock_out(src[0]),
    .mii_tx_en(src[5]), .mii_rx_dv(src[4]), .mii_tx_clk(src[3]),
    .mii_rx_clk(src[2]), .eeprom_data_pin_i(ee_lvl),
    .eeprom_data_pin_o(ed_o), .eeprom_data_pin_oe(ed_oe),
    .eeprom_clock_pin_o(ec_o), .eeprom_clock_pin_oe(ec_oe));
  glp_pin_model u_glp_pin_model (.pin_o(pin_o), .pin_oe(pin_oe),
    .ee_o(ed_o), .ee_oe(ed_oe), .ext_val(ext_val), .ext_oe(ext_oe),
    .pin_lvl(pin_lvl), .ee_lvl(ee_lvl));
  initial begin
    ref_clk = 1'h0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
    #1;
  endtask : wr
  task automatic rd(logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic final_report;
    $display("errors %0d compares %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  // after reset only the pulled-up pin levels read back
  task automatic t_reset;
    logic [31:0] d;
    cyc(3);  // let the pin synchroniser fill before the first read
    rd(8'h88, d);
    chk("cfg", 32'h0000_0007, d);
    chk("oe", 32'h0, {29'h0, pin_oe});
    chk("ck_oe", 32'h1, {31'h0, ec_oe});
  endtask : t_reset
  // all ones: reserved bits stay zero, leds take the pins
  task automatic t_fields;
    logic [31:0] d;
    wr(8'h88, 32'hFFFF_FFFF);
    wr(8'h8C, 32'h0000_0000);
    rd(8'h88, d);
    chk("cfg", 32'h7777_071A, d);
    chk("led", {29'h0, ~led_status}, {29'h0, pin_lvl});
    rd(8'h8C, d);
    chk("unmapped", 32'h0, d);
  endtask : t_fields
  // two push-pull pins and one open-drain pin
  task automatic t_drive;
    logic [31:0] d;
    wr(8'h88, 32'h0003_0705);
    chk("pins", 32'h5, {29'h0, pin_lvl});
    chk("oe", 32'h3, {29'h0, pin_oe});
    wr(8'h88, 32'h0003_0701);
    cyc(2);  // data bits read the pins two flops late
    rd(8'h88, d);
    chk("cfg", 32'h0003_0701, d);
    chk("oe", 32'h7, {29'h0, pin_oe});
  endtask : t_drive
  // every legal role code; second pass flips every source
  task automatic t_eeprom;
    logic [2:0] code [6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
    logic [1:0] exp [6] = '{2'h2, 2'h1, 2'h0, 2'h3, 2'h2, 2'h1};
    for (int p = 0; p < 2; p++) begin
      @(posedge ref_clk);
      src <= p[0] ? 6'h19 : 6'h26;  // controller drives data on the first pass, idle on the second
      ee_data_oe <= ~p[0];
      for (int i = 0; i < 6; i++) begin
        wr(8'h88, {9'h0, code[i], 15'h0, ~p[0], p[0], 3'h0});
        chk("ee", {28'h0, exp[i] ^ {2{p[0]}}, ~p[0] | (code[i] != 3'h0),
          1'h1}, {28'h0, ed_o, ec_o, ed_oe, ec_oe});
        chk("ee_in", {31'h0, ee_lvl}, {31'h0, ee_in});
      end
    end
  endtask : t_eeprom
  // polarity picks the active level; enable gates the request
  task automatic t_irq;
    logic [31:0] d;
    int k;
    @(posedge ref_clk);
    ext_oe <= 3'h7;
    ext_val <= 3'h1;  // held far beyond 40 ns
    wr(8'h88, 32'h0100_0000);
    for (k = 0; k < 8 && irq_lvl[0] !== 1'h1; k++) cyc(1);
    if (k == 8) begin
      error_cnt++;
      final_report();
    end
    chk("irq off", 32'h0, {31'h0, pin_irq});
    rd(8'h88, d);
    chk("cfg", 32'h0100_0001, d);
    @(posedge ref_clk);
    irq_en <= 3'h1;
    cyc(3);
    chk("irq on", 32'h1, {31'h0, pin_irq});
    wr(8'h88, 32'h0000_0000);
    cyc(5);
    chk("lvl", 32'h6, {29'h0, irq_lvl});
    chk("irq gated", 32'h0, {31'h0, pin_irq});
  endtask : t_irq
  initial begin
    error_cnt = 0;
    n_compared = 0;
    {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {ext_val, ext_oe, irq_en, ee_data_oe} = '0;
    led_status = 3'h5;
    src = 6'h26;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'h1;
    t_reset();
    t_fields();
    t_drive();
    t_eeprom();
    t_irq();
    final_report();
  end
endmodule : tb_gpio_led_pin_config
